/* File: verilog/adc_host_pkg.sv */
package adc_host_pkg;
	localparam int          RESULT_BITS     = 18;
	localparam int          CLK_HZ          = 40000000;
	localparam int          CNV_LOW_NS      = 25;
	localparam int          CNV_LOW_CYC     = (CNV_LOW_NS * CLK_HZ
		+ 999999999) / 1000000000;
	localparam int          SCLK_DIV        = 2;
	localparam logic [4:0]  BITS_RESET      = 5'h00;
	localparam logic [17:0] RESULT_RESET    = 18'h00000;
	localparam logic [3:0]  CNV_CNT_RESET   = 4'h0;
	localparam logic [1:0]  DIV_RESET       = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_START,
		ST_WAIT_BUSY,
		ST_SELECT,
		ST_SHIFT,
		ST_DONE
	} host_state_t;
endpackage

/* File: verilog/adc_serial_host.sv */
`timescale 1ns/10ps
module adc_serial_host
	import adc_host_pkg::*;
#(
	parameter int BITS = RESULT_BITS
)(
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            start_i,
	output logic                 done_o,
	output logic [BITS-1:0]      result_o,
	output logic                 overrun_o,
	input  wire logic            busy_i,
	input  wire logic            serial_data_out_i,
	input  wire logic            read_overrun_pulse_i,
	output logic                 convert_start_n_o,
	output logic                 chip_select_n_o,
	output logic                 read_enable_n_o,
	output logic                 sclk_o,
	output logic                 clock_source_select_o,
	output logic                 interface_select_lo_o,
	output logic                 interface_select_hi_o,
	output logic                 chain_data_in_o
);
	import adc_host_pkg::*;

	host_state_t     state_q, state_d;
	logic [3:0]      cnv_cnt_q;
	logic [4:0]      bits_q;
	logic [BITS-1:0] shreg_q;
	logic [1:0]      div_q;
	logic [1:0]      busy_s_q, sdo_s_q, err_s_q;
	logic            err_prev_q;
	logic            busy_seen_q;

	wire busy_s    = busy_s_q[1];
	wire sdo_s     = sdo_s_q[1];
	wire err_rise  = err_s_q[1] & ~err_prev_q;
	wire div_tick  = (div_q == 2'(SCLK_DIV - 1));
	wire last_bit  = (bits_q == 5'(BITS - 1));
	wire cnv_done  = (cnv_cnt_q == 4'(CNV_LOW_CYC));
	wire in_shift  = (state_q == ST_SHIFT);
	// Sample at the fall: synced bit is the one shown at the rise
	wire fall_en   = in_shift & div_tick & sclk_o;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (start_i)
					state_d = ST_START;
			ST_START:
				if (cnv_done)
					state_d = ST_WAIT_BUSY;
			ST_WAIT_BUSY:
				if (busy_seen_q && !busy_s)
					state_d = ST_SELECT;
			ST_SELECT:
				if (div_tick)
					state_d = ST_SHIFT;
			ST_SHIFT:
				if (fall_en && last_bit)
					state_d = ST_DONE;
			ST_DONE:
				state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			busy_s_q   <= 2'h3;
			sdo_s_q    <= 2'h0;
			err_s_q    <= 2'h0;
			err_prev_q <= 1'b0;
		end
		else
		begin
			busy_s_q   <= {busy_s_q[0], busy_i};
			sdo_s_q    <= {sdo_s_q[0], serial_data_out_i};
			err_s_q    <= {err_s_q[0], read_overrun_pulse_i};
			err_prev_q <= err_s_q[1];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Busy must be seen high first, else a stale low starts an early read
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			busy_seen_q <= 1'b0;
		else
			busy_seen_q <= (state_q == ST_WAIT_BUSY)
				&& (busy_seen_q || busy_s);
	end

	// Convert start low pulse, held once per request
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnv_cnt_q         <= CNV_CNT_RESET;
			convert_start_n_o <= 1'b1;
		end
		else
		begin
			cnv_cnt_q <= (state_q == ST_START) ? cnv_cnt_q + 4'h1
				: CNV_CNT_RESET;
			convert_start_n_o <= !(state_q == ST_START && !cnv_done);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			div_q <= DIV_RESET;
		else if (div_tick || state_q == ST_IDLE)
			div_q <= DIV_RESET;
		else
			div_q <= div_q + 2'h1;
	end

	// Gated clock idling low; 10 MHz stays under both limits
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			sclk_o <= 1'b0;
		else if (in_shift && div_tick)
			sclk_o <= ~sclk_o;
		else if (!in_shift)
			sclk_o <= 1'b0;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			chip_select_n_o <= 1'b1;
			read_enable_n_o <= 1'b1;
		end
		else
		begin
			chip_select_n_o <= !(state_d == ST_SELECT
				|| state_d == ST_SHIFT);
			read_enable_n_o <= !(state_d == ST_SELECT
				|| state_d == ST_SHIFT);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			bits_q  <= BITS_RESET;
			shreg_q <= '0;
		end
		else if (state_q == ST_SELECT)
			bits_q <= BITS_RESET;
		else
		begin
			if (fall_en)
			begin
				shreg_q <= {shreg_q[BITS-2:0], sdo_s};
				bits_q  <= bits_q + 5'h01;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			done_o    <= 1'b0;
			result_o  <= '0;
			overrun_o <= 1'b0;
		end
		else
		begin
			done_o    <= (state_q == ST_DONE);
			overrun_o <= err_rise;
			if (state_q == ST_DONE)
				result_o <= shreg_q;
		end
	end

	// Fixed straps: serial slave, no chaining
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			clock_source_select_o <= 1'b1;
			interface_select_lo_o <= 1'b1;
			interface_select_hi_o <= 1'b1;
			chain_data_in_o       <= 1'b0;
		end
		else
		begin
			clock_source_select_o <= 1'b1;
			interface_select_lo_o <= 1'b1;
			interface_select_hi_o <= 1'b1;
			chain_data_in_o       <= 1'b0;
		end
	end
endmodule

/* File: verif/adc_host_asserts.sv */
`timescale 1ns/10ps
module adc_host_asserts (
	input	wire logic	clk_i,
	input	wire logic	rst_i,
	input	wire logic	done_o,
	input	wire logic	overrun_o,
	input	wire logic	busy_i,
	input	wire logic	read_overrun_pulse_i,
	input	wire logic	convert_start_n_o,
	input	wire logic	chip_select_n_o,
	input	wire logic	read_enable_n_o,
	input	wire logic	sclk_o,
	input	wire logic	clock_source_select_o,
	input	wire logic	interface_select_lo_o,
	input	wire logic	interface_select_hi_o,
	input	wire logic	chain_data_in_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	straps_fixed_a: assert property (clock_source_select_o
		&& interface_select_hi_o && interface_select_lo_o
		&& !chain_data_in_o) else $error("straps");
	busy_wait_a: assert property ($fell(chip_select_n_o) |-> !busy_i)
		else $error("select in busy");
	done_pulse_a: assert property (done_o |=> !done_o)
		else $error("done width");
	select_pair_a: assert property (chip_select_n_o == read_enable_n_o)
		else $error("cs rd split");
	sclk_gated_a: assert property (sclk_o |-> !chip_select_n_o)
		else $error("sclk unselected");
	sclk_busy_a: assert property ($rose(sclk_o) |-> !busy_i)
		else $error("sclk in busy");
	sclk_rate_a: assert property ($rose(sclk_o) |=> sclk_o ##1 !sclk_o)
		else $error("sclk rate");
	cnv_pulse_a: assert property ($fell(convert_start_n_o)
		|=> convert_start_n_o) else $error("cnv width");
	done_end_a: assert property ($rose(chip_select_n_o) |-> ##[0:3] done_o)
		else $error("no done");
	overrun_seen_a: assert property ($rose(read_overrun_pulse_i)
		|-> ##[1:5] overrun_o) else $error("no overrun");
endmodule
bind adc_serial_host adc_host_asserts chk_u (.*);

/* File: verif/adc_dev_model.sv */
`timescale 1ns/10ps
module adc_dev_model #(
	parameter int	CONV_NS = 600
)(
	input	wire logic		cnv_n_i,
	input	wire logic		cs_n_i,
	input	wire logic		rd_n_i,
	input	wire logic		sclk_i,
	input	wire logic		ovr_i,
	input	wire logic [17:0]	value_i,
	input	wire logic		src_sel_i,
	input	wire logic		if_lo_i,
	input	wire logic		if_hi_i,
	input	wire logic		chain_i,
	output	logic			busy_o,
	output	logic			sdo_o,
	output	logic			rdo_o
);
	logic [17:0]	sr = 18'h00000;
	logic		chain_q = 1'b0;
	wire		serial_on = src_sel_i && if_lo_i && if_hi_i;
	initial busy_o = 1'b0;
	assign rdo_o = ovr_i;
	// Unselected line shows inverse, not a stale bit
	assign sdo_o = (serial_on && !cs_n_i && !rd_n_i) ? sr[17]
		: ~sr[17];
	always @(negedge cnv_n_i)
	begin
		busy_o = 1'b1;
		#CONV_NS sr = value_i;
		busy_o = 1'b0;
	end
	// Chain bit taken on the edge opposite the shift
	always @(posedge sclk_i)
		if (!cs_n_i)
			chain_q = chain_i;
	always @(negedge sclk_i)
		if (!cs_n_i && serial_on)
			sr = {sr[16:0], chain_q};
endmodule

/* File: verif/adc_serial_host_tb.sv */
`timescale 1ns/10ps
module adc_serial_host_tb;
	logic		clk_i = 0, rst_i = 1, start_i = 0, ovr = 0;
	logic [17:0]	val = 18'h00000, result_o;
	logic		done_o, overrun_o, busy, sdo, rdo, cnv_n, cs_n, rd_n, sclk;
	logic		src_sel, if_lo, if_hi, chain;
	int		error_cnt = 0, cmp_count = 0, pulses, n;
	adc_serial_host dut_u (.clk_i, .rst_i, .start_i, .done_o, .result_o,
		.overrun_o, .busy_i(busy), .serial_data_out_i(sdo),
		.read_overrun_pulse_i(rdo), .convert_start_n_o(cnv_n),
		.chip_select_n_o(cs_n), .read_enable_n_o(rd_n), .sclk_o(sclk),
		.clock_source_select_o(src_sel), .interface_select_lo_o(if_lo),
		.interface_select_hi_o(if_hi), .chain_data_in_o(chain));
	adc_dev_model dev_u (.cnv_n_i(cnv_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
		.sclk_i(sclk), .ovr_i(ovr), .value_i(val), .busy_o(busy),
		.sdo_o(sdo), .rdo_o(rdo), .src_sel_i(src_sel), .if_lo_i(if_lo),
		.if_hi_i(if_hi), .chain_i(chain));
	initial forever #12.5 clk_i = ~clk_i;
	always @(posedge sclk) pulses++;
	task chk(input logic [17:0] got, input logic [17:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task convert(input logic [17:0] v);
		@(posedge clk_i);
		val <= v;
		start_i <= 1'b1;
		pulses = 0;
		@(posedge clk_i);
		start_i <= 1'b0;
		for (n = 0; n < 2000 && done_o !== 1'b1; n++)
			@(posedge clk_i) #1;
		if (n == 2000)
		begin
			error_cnt++;
			complete_run();
		end
		chk(result_o, v);
		chk(18'(pulses), 18'h12);
		$display("read %h done", v);
	endtask
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		convert(18'h3ffff);
		convert(18'h20001);
		convert(18'h15a5a);
		convert(18'h00000);
		@(posedge clk_i);
		ovr <= 1'b1;
		for (n = 0; n < 8 && overrun_o !== 1'b1; n++)
			@(posedge clk_i) #1;
		chk(18'(n < 8), 18'h00001);
		$display("overrun done");
		complete_run();
	end
endmodule
